// file: common/charge_counter_pkg.sv
/*
 * Constants and carrier types for the charge accumulator counter.
 * Assumes the serial port engine presents register accesses as
 * one-cycle read or write requests on the core clock.
 */
package charge_counter_pkg;

    // Register offsets as seen through the serial port
    localparam logic [7:0] ALERT_ENABLE_OFFS = 8'h0d;
    localparam logic [7:0] LOW_LIMIT_OFFS = 8'h10;
    localparam logic [7:0] HIGH_LIMIT_OFFS = 8'h11;
    localparam logic [7:0] PRESCALE_OFFS = 8'h12;
    localparam logic [7:0] ACCUM_OFFS = 8'h13;
    localparam logic [7:0] CONFIG_OFFS = 8'h14;
    localparam logic [7:0] ALERT_FLAG_OFFS = 8'h1f;

    // Field positions
    localparam int unsigned LOW_ALERT_EN_BIT = 13;
    localparam int unsigned HIGH_ALERT_EN_BIT = 12;
    localparam int unsigned COUNT_EN_BIT = 2;
    localparam int unsigned LOW_FLAG_BIT = 1;
    localparam int unsigned HIGH_FLAG_BIT = 0;

    // Values after reset
    localparam logic [15:0] PRESCALE_RESET = 16'h0200;
    localparam logic [15:0] LOW_LIMIT_RESET = 16'h0000;
    localparam logic [15:0] HIGH_LIMIT_RESET = 16'hffff;
    localparam logic [15:0] ACCUM_RESET = 16'h0000;
    localparam logic ENABLE_RESET = 1'b0;

    // Saturation bounds of the accumulator
    localparam logic [15:0] ACCUM_MAX = 16'hffff;
    localparam logic [15:0] ACCUM_MIN = 16'h0000;

    // One register access from the serial port engine
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    // Front-end levels, raw or filtered: tick, switch state, ramp direction
    typedef struct packed {
        logic tick;
        logic sw;
        logic ramp;
    } front_lvl_t;

endpackage : charge_counter_pkg

// file: hdl/charge_accumulator_counter.sv
/*
 * Charge accumulator counter: front-end tick filtering, prescaler,
 * saturating 16-bit accumulator, limit alerts and register file.
 * Assumes the serial port engine outside decodes the bus protocol and
 * hands over single-cycle requests; front-end pins are asynchronous.
 */
`timescale 1ns/1ps
module charge_accumulator_counter
    import charge_counter_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic SRST_I,
    input wire logic TICK_I,
    input wire logic SWITCH_STATE_I,
    input wire logic RAMP_DIR_I,
    input wire reg_req_t REG_REQ_I,
    output logic [15:0] REG_RDATA_O,
    output logic REG_RVALID_O,
    output logic SMBALERT_N_O,
    output logic HIGH_LIMIT_ALERT_FLAG_O,
    output logic LOW_LIMIT_ALERT_FLAG_O
);

    // Three-stage pin synchronisers, one bit per front-end input
    front_lvl_t sync1_r;
    front_lvl_t sync2_r;
    front_lvl_t sync3_r;
    front_lvl_t lvl_r;
    front_lvl_t lvl_nxt;
    front_lvl_t pins;

    logic count_en_r;
    logic low_alert_enable_r;
    logic high_alert_enable_r;
    logic [15:0] low_limit_r;
    logic [15:0] high_limit_r;
    logic [15:0] presc_factor_r;
    logic [15:0] presc_cnt_r;
    logic [15:0] presc_cnt_nxt;
    logic [15:0] acc_r;
    logic [15:0] acc_nxt;
    logic high_flag_r;
    logic high_flag_nxt;
    logic low_flag_r;
    logic low_flag_nxt;
    logic smbalert_n_r;
    logic [15:0] rdata_r;
    logic rvalid_r;

    assign pins = '{tick: TICK_I, sw: SWITCH_STATE_I, ramp: RAMP_DIR_I};

    // A level is taken only when stages two and three agree
    wire front_lvl_t agree = ~(sync2_r ^ sync3_r);
    assign lvl_nxt = (agree & sync2_r) | (~agree & lvl_r);

    wire tick_pulse = lvl_nxt.tick & ~lvl_r.tick;
    // Switch state and ramp direction together give the polarity
    wire tick_up = lvl_r.sw ^ lvl_r.ramp;
    wire step = tick_pulse & count_en_r;

    // Register decode
    wire wr_alert_en = REG_REQ_I.wr && REG_REQ_I.addr == ALERT_ENABLE_OFFS;
    wire wr_low_lim = REG_REQ_I.wr && REG_REQ_I.addr == LOW_LIMIT_OFFS;
    wire wr_high_lim = REG_REQ_I.wr && REG_REQ_I.addr == HIGH_LIMIT_OFFS;
    wire wr_presc = REG_REQ_I.wr && REG_REQ_I.addr == PRESCALE_OFFS;
    wire wr_acc = REG_REQ_I.wr && REG_REQ_I.addr == ACCUM_OFFS;
    wire wr_cfg = REG_REQ_I.wr && REG_REQ_I.addr == CONFIG_OFFS;
    wire wr_flag = REG_REQ_I.wr && REG_REQ_I.addr == ALERT_FLAG_OFFS;

    // A factor of zero would stall the prescaler, so it acts as one
    wire [15:0] presc_top = (presc_factor_r == 16'h0000) ? 16'h0000 :
        presc_factor_r - 16'h0001;
    wire overflow = step & tick_up & (presc_cnt_r >= presc_top);
    wire underflow = step & ~tick_up & (presc_cnt_r == 16'h0000);

    always_comb
    begin
        presc_cnt_nxt = presc_cnt_r;
        if (overflow)
        begin
            presc_cnt_nxt = 16'h0000;
        end
        else if (underflow)
        begin
            presc_cnt_nxt = presc_top;
        end
        else if (step)
        begin
            presc_cnt_nxt = tick_up ? presc_cnt_r + 16'h0001 :
                presc_cnt_r - 16'h0001;
        end
    end

    // Host write wins over a same-cycle tick so a calibration value sticks
    always_comb
    begin
        acc_nxt = acc_r;
        if (wr_acc)
        begin
            acc_nxt = REG_REQ_I.wdata;
        end
        else if (overflow && acc_r != ACCUM_MAX)
        begin
            acc_nxt = acc_r + 16'h0001;
        end
        else if (underflow && acc_r != ACCUM_MIN)
        begin
            acc_nxt = acc_r - 16'h0001;
        end
    end

    wire high_hit = high_alert_enable_r && acc_r > high_limit_r;
    wire low_hit = low_alert_enable_r && acc_r < low_limit_r;
    wire high_clr = wr_flag && REG_REQ_I.wdata[HIGH_FLAG_BIT];
    wire low_clr = wr_flag && REG_REQ_I.wdata[LOW_FLAG_BIT];
    // Set wins over a clear in the same cycle
    assign high_flag_nxt = high_hit | (high_flag_r & ~high_clr);
    assign low_flag_nxt = low_hit | (low_flag_r & ~low_clr);

    wire [15:0] rd_mux =
        (REG_REQ_I.addr == ALERT_ENABLE_OFFS) ?
            16'(({15'h0000, low_alert_enable_r} << LOW_ALERT_EN_BIT) |
                ({15'h0000, high_alert_enable_r} << HIGH_ALERT_EN_BIT)) :
        (REG_REQ_I.addr == LOW_LIMIT_OFFS) ? low_limit_r :
        (REG_REQ_I.addr == HIGH_LIMIT_OFFS) ? high_limit_r :
        (REG_REQ_I.addr == PRESCALE_OFFS) ? presc_factor_r :
        (REG_REQ_I.addr == ACCUM_OFFS) ? acc_r :
        (REG_REQ_I.addr == CONFIG_OFFS) ?
            16'({15'h0000, count_en_r} << COUNT_EN_BIT) :
        (REG_REQ_I.addr == ALERT_FLAG_OFFS) ?
            16'(({15'h0000, low_flag_r} << LOW_FLAG_BIT) |
                ({15'h0000, high_flag_r} << HIGH_FLAG_BIT)) :
        16'h0000;

    always_ff @(posedge CORE_CLK_I)
    begin
        sync1_r <= pins;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SRST_I)
        begin
            lvl_r <= '0;
            presc_cnt_r <= 16'h0000;
            acc_r <= ACCUM_RESET;
        end
        else
        begin
            lvl_r <= lvl_nxt;
            presc_cnt_r <= presc_cnt_nxt;
            acc_r <= acc_nxt;
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SRST_I)
        begin
            count_en_r <= ENABLE_RESET;
            low_alert_enable_r <= ENABLE_RESET;
            high_alert_enable_r <= ENABLE_RESET;
        end
        else
        begin
            if (wr_cfg)
            begin
                count_en_r <= REG_REQ_I.wdata[COUNT_EN_BIT];
            end
            if (wr_alert_en)
            begin
                low_alert_enable_r <= REG_REQ_I.wdata[LOW_ALERT_EN_BIT];
                high_alert_enable_r <= REG_REQ_I.wdata[HIGH_ALERT_EN_BIT];
            end
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SRST_I)
        begin
            low_limit_r <= LOW_LIMIT_RESET;
            high_limit_r <= HIGH_LIMIT_RESET;
            presc_factor_r <= PRESCALE_RESET;
        end
        else
        begin
            if (wr_low_lim)
            begin
                low_limit_r <= REG_REQ_I.wdata;
            end
            if (wr_high_lim)
            begin
                high_limit_r <= REG_REQ_I.wdata;
            end
            if (wr_presc)
            begin
                presc_factor_r <= REG_REQ_I.wdata;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (SRST_I)
        begin
            high_flag_r <= 1'b0;
            low_flag_r <= 1'b0;
            smbalert_n_r <= 1'b1;
            rdata_r <= 16'h0000;
            rvalid_r <= 1'b0;
        end
        else
        begin
            high_flag_r <= high_flag_nxt;
            low_flag_r <= low_flag_nxt;
            smbalert_n_r <= ~(high_flag_nxt | low_flag_nxt);
            rvalid_r <= REG_REQ_I.rd;
            if (REG_REQ_I.rd)
            begin
                rdata_r <= rd_mux;
            end
        end
    end

    assign REG_RDATA_O = rdata_r;
    assign REG_RVALID_O = rvalid_r;
    assign SMBALERT_N_O = smbalert_n_r;
    assign HIGH_LIMIT_ALERT_FLAG_O = high_flag_r;
    assign LOW_LIMIT_ALERT_FLAG_O = low_flag_r;

    property p_hold_when_disabled;
        @(posedge CORE_CLK_I) disable iff (SRST_I)
        (!count_en_r && !wr_acc) |=> acc_r == $past(acc_r)
            && presc_cnt_r == $past(presc_cnt_r);
    endproperty
    a_hold_when_disabled: assert property (p_hold_when_disabled)
        else $error("count or prescaler moved while disabled");

    property p_disabled_after_reset;
        @(posedge CORE_CLK_I)
        SRST_I |=> !count_en_r;
    endproperty
    a_disabled_after_reset: assert property (p_disabled_after_reset)
        else $error("counter enabled after reset");

    property p_prescale_reset;
        @(posedge CORE_CLK_I)
        $fell(SRST_I) |-> presc_factor_r == PRESCALE_RESET;
    endproperty
    a_prescale_reset: assert property (p_prescale_reset)
        else $error("prescale factor not 512 after reset");

    property p_high_flag_needs_enable;
        @(posedge CORE_CLK_I) disable iff (SRST_I)
        $rose(high_flag_r) |-> $past(high_alert_enable_r)
            && $past(acc_r) > $past(high_limit_r);
    endproperty
    a_high_flag_needs_enable: assert property (p_high_flag_needs_enable)
        else $error("high flag set without enable or excess");

    property p_low_sets;
        @(posedge CORE_CLK_I) disable iff (SRST_I)
        (low_alert_enable_r && acc_r < low_limit_r) |=> low_flag_r
            && !SMBALERT_N_O;
    endproperty
    a_low_sets: assert property (p_low_sets)
        else $error("low limit alert not raised");

    property p_alert_line;
        @(posedge CORE_CLK_I) disable iff (SRST_I)
        (high_flag_r || low_flag_r) |-> !SMBALERT_N_O;
    endproperty
    a_alert_line: assert property (p_alert_line)
        else $error("alert line idle while a flag is set");

    property p_acc_write;
        @(posedge CORE_CLK_I) disable iff (SRST_I)
        wr_acc |=> acc_r == $past(REG_REQ_I.wdata);
    endproperty
    a_acc_write: assert property (p_acc_write)
        else $error("accumulator write lost");

    property p_overflow_inc;
        @(posedge CORE_CLK_I) disable iff (SRST_I)
        (overflow && !wr_acc && acc_r != ACCUM_MAX)
            |=> acc_r == $past(acc_r) + 16'h0001;
    endproperty
    a_overflow_inc: assert property (p_overflow_inc)
        else $error("overflow did not add one count");

    property p_saturate_low;
        @(posedge CORE_CLK_I) disable iff (SRST_I)
        (underflow && !wr_acc && acc_r == ACCUM_MIN) |=> acc_r == ACCUM_MIN;
    endproperty
    a_saturate_low: assert property (p_saturate_low)
        else $error("accumulator wrapped below zero");

    property p_read_count;
        @(posedge CORE_CLK_I) disable iff (SRST_I)
        (REG_REQ_I.rd && REG_REQ_I.addr == ACCUM_OFFS)
            |=> REG_RVALID_O && REG_RDATA_O == $past(acc_r);
    endproperty
    a_read_count: assert property (p_read_count)
        else $error("count read returned wrong value");

    c_overflow: cover property (@(posedge CORE_CLK_I) overflow);
    c_underflow: cover property (@(posedge CORE_CLK_I) underflow);
    c_high_alert: cover property (@(posedge CORE_CLK_I) $rose(high_flag_r));
    c_low_alert: cover property (@(posedge CORE_CLK_I) $rose(low_flag_r));

endmodule : charge_accumulator_counter

// file: test/host_port_model.sv
/*
 * Host side of the register port: one-cycle read and write requests.
 * Assumes the device answers a read exactly one cycle after taking it.
 */
`timescale 1ns/1ps
module host_port_model
    import charge_counter_pkg::*;
(
    input wire logic clk_i,
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i,
    output reg_req_t req_o
);
    initial req_o = '0;

    // The port never stalls, so each request stands for exactly one edge
    task automatic acc(input logic w, input logic [7:0] a,
        input logic [15:0] d, output logic [15:0] q, output logic ok);
        int n;
        @(negedge clk_i);
        req_o = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk_i);
        req_o = '0;
        n = 0;
        while (!w && rvalid_i !== 1'b1 && n < 4)
        begin
            @(negedge clk_i);
            n++;
        end
        // A late answer is a failure even though the loop waits for it
        ok = w || (rvalid_i === 1'b1 && n == 0);
        q = rdata_i;
    endtask : acc

    // Recharge setup after a full-charge alert, and its reversal
    task automatic swap(input logic to_low, input logic [15:0] lo);
        logic [15:0] q;
        logic ok;
        if (to_low)
            acc(1'b1, LOW_LIMIT_OFFS, lo, q, ok);
        acc(1'b1, ALERT_ENABLE_OFFS, to_low ? 16'h2000 : 16'h1000, q, ok);
    endtask : swap
endmodule : host_port_model

// file: test/charge_accumulator_counter_test.sv
/*
 * Self-checking bench for the charge accumulator counter.
 * Assumes the host model above and a reference model kept in integers.
 */
`timescale 1ns/1ps
module charge_accumulator_counter_test;
    import charge_counter_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic tick = 1'b0;
    logic sw = 1'b0;
    logic ramp = 1'b0;
    reg_req_t req;
    logic [15:0] rdata;
    logic rvalid, alert_n, hi_f, lo_f, ok;
    logic [15:0] q;
    int err_total = 0;
    int compares = 0;
    int seed = 18;
    int cnt = 0;
    int pre = 0;
    int fac = 512;
    int en = 0;
    logic [7:0] ra [8] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h0d,
        8'h1f, 8'h20};
    logic [15:0] rv [8] = '{16'h0000, 16'hffff, 16'h0200, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};

    always #25 clk = ~clk;

    charge_accumulator_counter i_dut (.CORE_CLK_I(clk), .SRST_I(srst),
        .TICK_I(tick), .SWITCH_STATE_I(sw), .RAMP_DIR_I(ramp),
        .REG_REQ_I(req), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
        .SMBALERT_N_O(alert_n), .HIGH_LIMIT_ALERT_FLAG_O(hi_f),
        .LOW_LIMIT_ALERT_FLAG_O(lo_f));
    host_port_model i_host (.clk_i(clk), .rdata_i(rdata),
        .rvalid_i(rvalid), .req_o(req));

    task automatic close_out;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk16

    task automatic chk1(string nm, logic e, logic g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    task automatic rd(logic [7:0] a, logic [15:0] e);
        i_host.acc(1'b0, a, 16'h0000, q, ok);
        chk1("read answer", 1'b1, ok);
        if (ok !== 1'b1)
            close_out();
        else
            chk16("read data", e, q);
    endtask : rd

    task automatic wr(logic [7:0] a, logic [15:0] d);
        i_host.acc(1'b1, a, d, q, ok);
        if (a == ACCUM_OFFS)
            cnt = d;
        if (a == PRESCALE_OFFS)
            fac = d;
        if (a == CONFIG_OFFS)
            en = d[2];
    endtask : wr

    // Levels settle before the tick edge so the filters agree on direction
    task automatic step(logic up);
        int f;
        @(negedge clk);
        sw = 1'($random(seed));
        ramp = sw ^ up;
        repeat (4) @(negedge clk);
        tick = 1'b1;
        repeat (4) @(negedge clk);
        tick = 1'b0;
        repeat (4) @(negedge clk);
        f = (fac == 0) ? 1 : fac;
        if (en == 0)
            return;
        if (up && pre >= f - 1)
        begin
            pre = 0;
            cnt = (cnt < 65535) ? cnt + 1 : cnt;
        end
        else if (up)
            pre++;
        else if (pre == 0)
        begin
            pre = f - 1;
            cnt = (cnt > 0) ? cnt - 1 : cnt;
        end
        else
            pre--;
    endtask : step

    initial
    begin
        repeat (16) @(posedge clk);
        @(negedge clk) srst = 1'b0;
        for (int i = 0; i < 8; i++)
            rd(ra[i], rv[i]);
        chk1("alert line", 1'b1, alert_n);
        wr(PRESCALE_OFFS, 16'h0003);
        repeat (2) step(1'b1);
        rd(ACCUM_OFFS, 16'h0000);
        wr(CONFIG_OFFS, 16'h0004);
        wr(ACCUM_OFFS, 16'h8000 ^ 16'($random(seed)));
        for (int k = 0; k < 2; k++)
        begin
            repeat (20)
            begin
                step(1'($random(seed)));
                rd(ACCUM_OFFS, cnt[15:0]);
            end
            wr(PRESCALE_OFFS, 16'h0001);
        end
        // Factor zero must behave as one for the saturation steps below
        wr(PRESCALE_OFFS, 16'h0000);
        wr(ACCUM_OFFS, ACCUM_MAX);
        step(1'b1);
        rd(ACCUM_OFFS, cnt[15:0]);
        wr(ACCUM_OFFS, ACCUM_MIN);
        step(1'b0);
        rd(ACCUM_OFFS, cnt[15:0]);
        wr(HIGH_LIMIT_OFFS, 16'h0010);
        wr(ACCUM_OFFS, 16'h0011);
        repeat (3) @(negedge clk);
        chk1("high flag masked", 1'b0, hi_f);
        wr(ALERT_ENABLE_OFFS, 16'h1000);
        repeat (3) @(negedge clk);
        chk1("high flag", 1'b1, hi_f);
        chk1("alert line", 1'b0, alert_n);
        rd(ALERT_FLAG_OFFS, 16'h0001);
        wr(ACCUM_OFFS, 16'h0010);
        i_host.swap(1'b1, 16'h000f);
        wr(ALERT_FLAG_OFFS, 16'h0001);
        repeat (3) @(negedge clk);
        chk1("high flag cleared", 1'b0, hi_f);
        step(1'b0);
        chk1("low flag at limit", 1'b0, lo_f);
        step(1'b0);
        chk1("low flag", 1'b1, lo_f);
        chk1("alert line", 1'b0, alert_n);
        // Clearing while the count is still below the limit must not win
        wr(ALERT_FLAG_OFFS, 16'h0002);
        repeat (3) @(negedge clk);
        chk1("low flag kept", 1'b1, lo_f);
        rd(ALERT_ENABLE_OFFS, 16'h2000);
        i_host.swap(1'b0, 16'h0000);
        wr(ALERT_FLAG_OFFS, 16'h0002);
        repeat (3) @(negedge clk);
        chk1("low flag cleared", 1'b0, lo_f);
        chk1("alert line", 1'b1, alert_n);
        close_out();
    end
endmodule : charge_accumulator_counter_test
